//--- design/ioer_pkg.sv
// ioer_pkg: shared constants for the isochronous OUT endpoint receive path.
// assumes a 32-bit APB register bus and a byte-wide receive stream on the same clock.
package ioer_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;  // enable and ping-pong mode
  localparam logic [7:0] OFS_EPSEL    = 8'h04;  // endpoint_select
  localparam logic [7:0] OFS_EPSTAT   = 8'h08;  // endpoint_status_reg, write 1 to clear flags
  localparam logic [7:0] OFS_CNTLO    = 8'h0C;  // rx_count_low
  localparam logic [7:0] OFS_CNTHI    = 8'h10;  // rx_count_high
  localparam logic [7:0] OFS_INTSTAT  = 8'h14;  // sticky event status, read only
  localparam logic [7:0] OFS_INTCLR   = 8'h18;  // event clear, write only
  localparam logic [7:0] OFS_INTEN    = 8'h1C;  // event enable
  localparam logic [7:0] OFS_FIFO     = 8'h20;  // fifo data, read pops one byte

  // control register fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_PP_BIT  = 1;
  localparam int CTRL_W       = 2;

  // endpoint status fields
  localparam int ST_B0_BIT    = 1;  // bank0_rx_done
  localparam int ST_CRC_BIT   = 3;  // stall_or_crc_flag
  localparam int ST_B1_BIT    = 6;  // bank1_rx_done

  // interrupt event fields
  localparam int EV_B0_BIT    = 0;
  localparam int EV_B1_BIT    = 1;
  localparam int EV_CRC_BIT   = 2;
  localparam int EV_W         = 3;

  localparam int EPSEL_W      = 4;
  localparam int COUNT_W      = 16;
  localparam int BYTE_W       = 8;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // receive sequencer, gray along idle -> store and drop -> store
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_STORE = 2'b01,
    RX_DROP  = 2'b11
  } ioer_rx_state_t;

endpackage

//--- design/ioer_mem_if.sv
// ioer_mem_if: write and read ports of the two-bank endpoint memory.
// assumes one clock shared by the endpoint logic and the memory.
`timescale 1ns/1ps
`default_nettype none
interface ioer_mem_if #(parameter int AW = 7);
  logic          wrEn;    // store one byte
  logic [AW-1:0] wrAddr;  // {bank, offset}
  logic [7:0]    wrData;  // byte to store
  logic [AW-1:0] rdAddr;  // {bank, offset}
  logic [7:0]    rdData;  // registered read byte

  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface
`default_nettype wire

//--- design/ioer_bank_mem.sv
// ioer_bank_mem: byte memory holding both endpoint banks.
// assumes the caller holds rdAddr one cycle before using rdData.
`timescale 1ns/1ps
`default_nettype none
module ioer_bank_mem #(
  parameter int AW = 7
) (
  input  wire logic clk,    // controller clock
  input  wire logic clkEn,  // freezes the memory while low
  ioer_mem_if.mem   port    // write and read port
);

  logic [7:0] store [2**AW];

  // no reset on the array: contents are only valid once a flag says so
  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (port.wrEn) begin
        store[port.wrAddr] <= port.wrData;
      end
      port.rdData <= store[port.rdAddr];
    end
  end

endmodule
`default_nettype wire

//--- design/iso_out_endpoint_receive.sv
// iso_out_endpoint_receive: isochronous OUT receive path of one USB endpoint,
// single-bank or ping-pong, with APB registers and one level interrupt.
// assumes the packet stream comes from the serial engine on the same clock,
// already decoded to bytes, with the CRC verdict given at packet end.
// one endpoint only; packets for other endpoints pass by untouched.
// clkEn low holds every register and the memory, apb included, so the
// bus side must not wait for an answer while it is low.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - single bank: received packet sets bank0 flag and interrupt if enabled
// - zero-length packet reports count zero in both count registers
// - crc flag set on bad crc, re-evaluated on each stored packet
// - single bank: while bank0 flag set, later packets are discarded
// - flag cleared mid-packet: only bytes after the clear are stored
// - bytes beyond fifo depth dropped, packet still valid on good crc
// - ping-pong: packet into bank0 sets bank0 flag and interrupt
// - ping-pong: clearing bank0 flag frees it and swaps the active bank
// - ping-pong: packet into bank1 sets bank1 flag; firmware drains first
// - ping-pong: data for a bank with flag set is discarded
// - ping-pong: bank0 and bank1 flags set alternately per packet
// - flag and count accesses apply to the selected endpoint only
module iso_out_endpoint_receive
  import ioer_pkg::*;
#(
  parameter int               DEPTH  = 64,     // bytes per bank
  parameter logic [EPSEL_W-1:0] EP_NUM = 4'h1  // this endpoint's number
) (
  input  wire logic               clk,       // controller clock, 40 MHz
  input  wire logic               rst_n,     // async reset, active low
  input  wire logic               clkEn,     // freezes all state while low
  input  wire logic               psel,      // apb select
  input  wire logic               penable,   // apb access phase
  input  wire logic               pwrite,    // apb write
  input  wire logic [7:0]         paddr,     // apb byte address
  input  wire logic [31:0]        pwdata,    // apb write data
  output logic      [31:0]        prdata,    // apb read data
  output logic                    pready,    // apb ready
  output logic                    pslverr,   // apb error, unmapped address
  input  wire logic               rxStart,   // pulse: OUT data packet begins
  input  wire logic [EPSEL_W-1:0] rxEp,      // endpoint of the packet, with rxStart
  input  wire logic               rxValid,   // pulse: one data byte
  input  wire logic [BYTE_W-1:0]  rxByte,    // data byte, with rxValid
  input  wire logic               rxEnd,     // pulse: packet ends
  input  wire logic               rxCrcOk,   // crc verdict, with rxEnd
  output logic                    irq        // level interrupt
);

  localparam int OW = $clog2(DEPTH);
  localparam int AW = OW + 1;
  localparam logic [COUNT_W-1:0] DEPTH_CNT = COUNT_W'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // fifo memory: both banks in one array, bank number is the top address bit
  // write side follows the host bank pointer, read side the firmware one

  ioer_mem_if #(.AW(AW)) memBus ();

  ioer_bank_mem #(.AW(AW)) uMem (
    .clk   (clk),
    .clkEn (clkEn),
    .port  (memBus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [CTRL_W-1:0]  ctrl_r;
  logic [EPSEL_W-1:0] epSel_r;
  logic [1:0]         done_r;       // bank receive flags
  logic               crcFlag_r;
  logic [COUNT_W-1:0] cnt_r [2];    // per-bank byte count
  logic [EV_W-1:0]    evStat_r;
  logic [EV_W-1:0]    evEn_r;
  logic               hwBank_r;     // bank the host fills next
  logic               fwBank_r;     // bank firmware reads
  logic [OW-1:0]      rdPtr_r;
  logic [COUNT_W-1:0] wrPtr_r;
  ioer_rx_state_t     rxState_r;
  logic               pready_r;
  logic               pslverr_r;
  logic [31:0]        prdata_r;

  logic enabled;
  logic pingPong;
  logic selOk;
  logic accDone;
  logic wrDone;
  logic rdDone;
  logic mapped;
  logic ctrlWr;
  logic [1:0] fwClear;
  logic finish;
  logic epstatWr;
  logic intclrWr;
  logic fifoPop;
  logic stored;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  // mode bits and the completing edge of an access
  assign enabled  = ctrl_r[CTRL_EN_BIT];
  assign pingPong = ctrl_r[CTRL_PP_BIT];
  assign selOk    = (epSel_r == EP_NUM);
  assign accDone  = psel & penable & pready_r;
  assign wrDone   = accDone & pwrite & mapped;
  assign rdDone   = accDone & ~pwrite & mapped;
  assign ctrlWr   = wrDone & (paddr == OFS_CTRL);

  // decoded strobes; epstat and fifo act only for the selected endpoint
  assign epstatWr = wrDone & (paddr == OFS_EPSTAT) & selOk;
  assign intclrWr = wrDone & (paddr == OFS_INTCLR);
  assign fifoPop  = rdDone & (paddr == OFS_FIFO) & selOk;

  // address decode
  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_EPSEL, OFS_EPSTAT, OFS_CNTLO, OFS_CNTHI,
      OFS_INTSTAT, OFS_INTCLR, OFS_INTEN, OFS_FIFO: mapped = 1'b1;
      default:                                       mapped = 1'b0;
    endcase
  end

  // write-one-to-clear of the bank flags, only for the selected endpoint;
  // a bank1 clear means nothing in single-bank mode and is ignored
  always_comb begin
    fwClear = 2'b00;
    if (epstatWr) begin
      fwClear[0] = pwdata[ST_B0_BIT];
      fwClear[1] = pwdata[ST_B1_BIT] & pingPong;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: every access ends in its second access cycle
  // the fixed wait state gives the fifo memory a cycle to show the byte at the read pointer

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clkEn) begin
      pready_r  <= psel & penable & ~pready_r;
      pslverr_r <= psel & penable & ~pready_r & ~mapped;
    end
  end

  // read data captured in the first access cycle, after memory has settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= RESET_WORD;
    end else if (clkEn && psel && penable && !pready_r) begin
      prdata_r <= RESET_WORD;
      unique case (paddr)
        OFS_CTRL:    prdata_r[CTRL_W-1:0]  <= ctrl_r;
        OFS_EPSEL:   prdata_r[EPSEL_W-1:0] <= epSel_r;
        OFS_EPSTAT: begin
          if (selOk) begin
            prdata_r[ST_B0_BIT]  <= done_r[0];
            prdata_r[ST_B1_BIT]  <= done_r[1];
            prdata_r[ST_CRC_BIT] <= crcFlag_r;
          end
        end
        OFS_CNTLO:   if (selOk) prdata_r[BYTE_W-1:0] <= cnt_r[fwBank_r][BYTE_W-1:0];
        OFS_CNTHI:   if (selOk) prdata_r[BYTE_W-1:0] <= cnt_r[fwBank_r][COUNT_W-1:BYTE_W];
        OFS_INTSTAT: prdata_r[EV_W-1:0] <= evStat_r;
        OFS_INTEN:   prdata_r[EV_W-1:0] <= evEn_r;
        OFS_FIFO:    if (selOk) prdata_r[BYTE_W-1:0] <= memBus.rdData;
        default:     prdata_r <= RESET_WORD;
      endcase
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  // any control write is a reconfiguration: bank flags drop, filling restarts at bank0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= '0;
      epSel_r <= '0;
      evEn_r  <= '0;
    end else if (clkEn && wrDone) begin
      if (paddr == OFS_CTRL)  ctrl_r  <= pwdata[CTRL_W-1:0];
      if (paddr == OFS_EPSEL) epSel_r <= pwdata[EPSEL_W-1:0];
      if (paddr == OFS_INTEN) evEn_r  <= pwdata[EV_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive sequencer

  logic hwFull;
  assign hwFull = done_r[hwBank_r];
  assign finish = (rxState_r == RX_STORE) & rxEnd;
  assign stored = finish & ~ctrlWr;  // a reconfig in the same cycle throws the packet away

  // a packet that finds its bank full is followed to its end in RX_DROP;
  // a late clear moves it to RX_STORE with the byte pointer at zero, so
  // the bank keeps only the tail of the packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_r <= RX_IDLE;
    end else if (clkEn) begin
      unique case (rxState_r)
        RX_IDLE: begin
          if (rxStart && rxEp == EP_NUM && enabled) begin
            rxState_r <= hwFull ? RX_DROP : RX_STORE;
          end
        end
        RX_STORE: begin
          if (rxEnd || ctrlWr) rxState_r <= RX_IDLE;
        end
        RX_DROP: begin
          if (rxEnd || ctrlWr) rxState_r <= RX_IDLE;
          else if (fwClear[hwBank_r]) rxState_r <= RX_STORE;
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  // byte pointer: restarts at the start or when a late clear opens the bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
    end else if (clkEn) begin
      if (rxState_r != RX_STORE) begin
        wrPtr_r <= '0;
      end else if (rxValid && wrPtr_r < DEPTH_CNT) begin
        wrPtr_r <= wrPtr_r + COUNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo ports

  // overflow bytes never reach memory, the count saturates at depth
  assign memBus.wrEn   = clkEn & (rxState_r == RX_STORE) & rxValid & (wrPtr_r < DEPTH_CNT);
  assign memBus.wrAddr = {hwBank_r, wrPtr_r[OW-1:0]};
  assign memBus.wrData = rxByte;
  assign memBus.rdAddr = {fwBank_r, rdPtr_r};

  ////////////////////////////////////////////////////////////////////////////
  // bank flags, counts and crc flag

  // counts are written only when a packet is kept, so they hold until the flag clears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_r    <= 2'b00;
      crcFlag_r <= 1'b0;
      cnt_r[0]  <= '0;
      cnt_r[1]  <= '0;
    end else if (clkEn) begin
      if (ctrlWr) begin
        done_r <= 2'b00;
      end else begin
        // clear first so a same-cycle set wins
        done_r <= done_r & ~fwClear;
        if (finish) begin
          done_r[hwBank_r]  <= 1'b1;
          cnt_r[hwBank_r]   <= wrPtr_r;
          crcFlag_r         <= ~rxCrcOk;
        end
      end
      // firmware clear of the crc flag loses to a packet ending in the same cycle
      if (epstatWr && pwdata[ST_CRC_BIT]) begin
        if (!finish) crcFlag_r <= 1'b0;
      end
    end
  end

  // bank pointers: host side alternates per stored packet, firmware side per clear
  // both sit at bank0 while ping-pong is off, so a later switch starts clean
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hwBank_r <= 1'b0;
      fwBank_r <= 1'b0;
    end else if (clkEn) begin
      if (ctrlWr || !pingPong) begin
        hwBank_r <= 1'b0;
        fwBank_r <= 1'b0;
      end else begin
        if (finish) hwBank_r <= ~hwBank_r;
        if (fwClear[fwBank_r]) fwBank_r <= ~fwBank_r;
      end
    end
  end

  // fifo read pointer: one byte per data read, back to zero on bank change
  // reads past the stored count wrap inside the bank; firmware reads only count bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPtr_r <= '0;
    end else if (clkEn) begin
      if (ctrlWr || fwClear != 2'b00) begin
        rdPtr_r <= '0;
      end else if (fifoPop) begin
        rdPtr_r <= rdPtr_r + OW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events: sticky, set beats clear

  logic [EV_W-1:0] evSet;
  logic [EV_W-1:0] evClr;

  // only kept packets raise events; a dropped one leaves everything as it was
  always_comb begin
    evSet = '0;
    evSet[EV_B0_BIT]  = stored & ~hwBank_r;
    evSet[EV_B1_BIT]  = stored & hwBank_r;
    evSet[EV_CRC_BIT] = stored & ~rxCrcOk;
    evClr = intclrWr ? pwdata[EV_W-1:0] : '0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evStat_r <= '0;
    end else if (clkEn) begin
      evStat_r <= (evStat_r & ~evClr) | evSet;
    end
  end

  // level output, follows status and enable
  assign irq = |(evStat_r & evEn_r);

endmodule
`default_nettype wire

//--- sim/ioer_usb_host.sv
// ioer_usb_host: host side sending isochronous OUT packets as a byte stream.
// assumes one shared clock; calls come from the bench's main sequence.
`timescale 1ns/1ps
`default_nettype none
module ioer_usb_host
  import ioer_pkg::*;
(
  input  wire logic               clk,     // controller clock
  output logic                    rxStart, // packet begins
  output logic      [EPSEL_W-1:0] rxEp,    // target endpoint
  output logic                    rxValid, // one byte
  output logic      [BYTE_W-1:0]  rxByte,  // data byte
  output logic                    rxEnd,   // packet ends
  output logic                    rxCrcOk  // crc verdict
);
  // quiet line at time zero
  initial begin
    rxStart = 1'b0;
    rxValid = 1'b0;
    rxEnd = 1'b0;
    rxCrcOk = 1'b0;
    rxEp = '0;
    rxByte = 8'hA5;
  end

  // bytes back to back; idle data inverted so stale values never match
  task automatic send(input logic [3:0] ep, input int n, input logic [7:0] first, input logic ok);
    @(posedge clk);
    rxStart <= 1'b1;
    rxEp <= ep;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxStart <= 1'b0;
      rxValid <= 1'b1;
      rxByte <= first + 8'(i);
    end
    @(posedge clk);
    rxStart <= 1'b0;
    rxValid <= 1'b0;
    rxByte <= ~rxByte;
    rxEnd <= 1'b1;
    rxCrcOk <= ok;
    @(posedge clk);
    rxEnd <= 1'b0;
    rxCrcOk <= ~ok;
    rxEp <= ~ep;
  endtask
endmodule
`default_nettype wire

//--- sim/ioer_assertions.sv
// ioer_assertions: port-level checks of the endpoint receive block.
// assumes clkEn held high; attached by the bind below.
`timescale 1ns/1ps
`default_nettype none
module ioer_assertions (
  input wire logic        clk,     // controller clock
  input wire logic        rst_n,   // async reset
  input wire logic        psel,    // apb select
  input wire logic        penable, // apb access
  input wire logic        pwrite,  // apb write
  input wire logic [31:0] prdata,  // read data
  input wire logic        pready,  // apb ready
  input wire logic        pslverr, // apb error
  input wire logic        rxEnd,   // packet end
  input wire logic        irq      // interrupt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // apb answer shape
  a_setup_ready: assert property (psel && !penable |-> ##2 pready) else $error("ready not two cycles after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error read not zero");
  // read data held between accesses
  a_rdata_hold: assert property (!psel |=> $stable(prdata)) else $error("read data moved while idle");
  ////////////////////////////////////////
  // interrupt moves only on packet end or register write
  a_irq_rise: assert property ($rose(irq) |-> $past(rxEnd) || $past(pready && pwrite))
    else $error("interrupt rose without cause");
  a_irq_fall: assert property ($fell(irq) |-> $past(pready && pwrite))
    else $error("interrupt fell without write");
endmodule
bind iso_out_endpoint_receive ioer_assertions u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxEnd(rxEnd), .irq(irq));
`default_nettype wire

//--- sim/iso_out_endpoint_receive_tb.sv
// iso_out_endpoint_receive_tb: register-level tests of the receive path.
// assumes the host model drives packets and clkEn stays high.
`timescale 1ns/1ps
`default_nettype none
module iso_out_endpoint_receive_tb
  import ioer_pkg::*;
;
  localparam int DEPTH = 8;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, err;
  logic        rxStart, rxValid, rxEnd, rxCrcOk;
  logic [3:0]  rxEp;
  logic [7:0]  rxByte;
  int          miscompares = 0;
  int          compares = 0;
  int          cyc = 0;

  always #12.5 clk = ~clk;

  iso_out_endpoint_receive #(.DEPTH(DEPTH), .EP_NUM(4'h1)) dut (.clk(clk), .rst_n(rst_n), .clkEn(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxStart(rxStart), .rxEp(rxEp), .rxValid(rxValid),
    .rxByte(rxByte), .rxEnd(rxEnd), .rxCrcOk(rxCrcOk), .irq(irq));
  ioer_usb_host host (.clk(clk), .rxStart(rxStart), .rxEp(rxEp), .rxValid(rxValid), .rxByte(rxByte),
    .rxEnd(rxEnd), .rxCrcOk(rxCrcOk));
  ////////////////////////////////////////
  task automatic wrap_up;
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; request held until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask

  // irq is combinational: look away from the edge
  task automatic irqChk(input logic exp);
    @(negedge clk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd("ctrl", OFS_CTRL, 32'h0);
    rd("intstat", OFS_INTSTAT, 32'h0);
    rd("unmapped", 8'h24, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    wr(OFS_EPSEL, 32'h1);
    wr(OFS_INTEN, 32'h7);
    rd("inten", OFS_INTEN, 32'h7);
    host.send(4'h1, 2, 8'h01, 1'b1);
    rd("epstat", OFS_EPSTAT, 32'h0);
    wr(OFS_CTRL, 32'h1);
    host.send(4'h1, 3, 8'h10, 1'b1);
    rd("epstat", OFS_EPSTAT, 32'h2);
    irqChk(1'b1);
    rd("cntlo", OFS_CNTLO, 32'h3);
    rd("cnthi", OFS_CNTHI, 32'h0);
    host.send(4'h1, 2, 8'h20, 1'b0);
    for (int i = 0; i < 3; i++) rd("fifo", OFS_FIFO, 32'(32'h10 + i));
    rd("epstat", OFS_EPSTAT, 32'h2);
    rd("intstat", OFS_INTSTAT, 32'h1);
    wr(OFS_INTEN, 32'h0);
    irqChk(1'b0);
    wr(OFS_INTEN, 32'h7);
    wr(OFS_EPSEL, 32'h2);
    rd("epstat", OFS_EPSTAT, 32'h0);
    rd("cntlo", OFS_CNTLO, 32'h0);
    wr(OFS_EPSEL, 32'h1);
    wr(OFS_EPSTAT, 32'h2);
    wr(OFS_INTCLR, 32'h7);
    irqChk(1'b0);
    host.send(4'h1, 0, 8'h00, 1'b0);
    rd("epstat", OFS_EPSTAT, 32'hA);
    rd("intstat", OFS_INTSTAT, 32'h5);
    rd("cntlo", OFS_CNTLO, 32'h0);
    rd("cnthi", OFS_CNTHI, 32'h0);
    wr(OFS_EPSTAT, 32'hA);
    host.send(4'h1, DEPTH + 2, 8'h30, 1'b1);
    rd("epstat", OFS_EPSTAT, 32'h2);
    rd("cntlo", OFS_CNTLO, 32'(DEPTH));
    // clear lands after the second byte slot
    fork
      host.send(4'h1, 6, 8'h40, 1'b1);
      wr(OFS_EPSTAT, 32'h2);
    join
    rd("cntlo", OFS_CNTLO, 32'h4);
    rd("fifo", OFS_FIFO, 32'h42);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_INTCLR, 32'h7);
    host.send(4'h2, 1, 8'h77, 1'b1);
    rd("epstat", OFS_EPSTAT, 32'h0);
    rd("intstat", OFS_INTSTAT, 32'h0);
    host.send(4'h1, 2, 8'h50, 1'b1);
    host.send(4'h1, 1, 8'h60, 1'b1);
    host.send(4'h1, 1, 8'h68, 1'b1);
    rd("epstat", OFS_EPSTAT, 32'h42);
    rd("intstat", OFS_INTSTAT, 32'h3);
    rd("cntlo", OFS_CNTLO, 32'h2);
    rd("fifo", OFS_FIFO, 32'h50);
    wr(OFS_EPSTAT, 32'h2);
    rd("cntlo", OFS_CNTLO, 32'h1);
    rd("fifo", OFS_FIFO, 32'h60);
    host.send(4'h1, 3, 8'h70, 1'b1);
    rd("epstat", OFS_EPSTAT, 32'h42);
    wr(OFS_EPSTAT, 32'h40);
    rd("cntlo", OFS_CNTLO, 32'h3);
    rd("fifo", OFS_FIFO, 32'h70);
    wrap_up();
  end
endmodule
`default_nettype wire
